// ==== shared/eiop_pkg.sv ====
// Package with register map, reset values and field positions of the eight-bit I/O port.
package eiop_pkg;
	localparam int eiop_width = 8;
	localparam logic [31:0] eiop_off_pin_direction = 32'h0000_0000;
	localparam logic [31:0] eiop_off_output_latch = 32'h0000_0004;
	localparam logic [31:0] eiop_off_pin_level_readback = 32'h0000_0008;
	localparam logic [7:0] eiop_rst_pin_direction = 8'h00;
	localparam logic [7:0] eiop_rst_output_latch = 8'h00;
	localparam logic [31:0] eiop_undef_read = 32'h0000_0000;
	localparam logic [1:0] eiop_htrans_nonseq = 2'h2;
	localparam logic [2:0] eiop_word_index = 3'h2;
	localparam int eiop_pat_base = 8;
	localparam int eiop_timer_ch_count = 3;
	localparam int eiop_interrupt_request_0_bit = 4;
	localparam int eiop_interrupt_request_1_bit = 6;
	localparam int eiop_clkc_bit = 5;
	localparam int eiop_clkd_bit = 7;
	localparam int eiop_clka_bit = 2;
	localparam int eiop_clkb_bit = 3;
endpackage

// ==== test/eiop_pads.sv ====
// Board pads: the port's drive wins, otherwise the board's level.
`timescale 1ns/1ns
module eiop_pads (
	input wire logic [7:0] pin_out, // Port drive.
	input wire logic [7:0] pin_oe, // Port enable.
	input wire logic [7:0] board, // Board level.
	output logic [7:0] pin_in // Pad level.
);
	assign pin_in = (pin_oe & pin_out) | (~pin_oe & board);
endmodule

// ==== test/eiop_port_assertions.sv ====
// Checker for bus read data and pin timing of the eight-bit port.
`timescale 1ns/1ns
module eiop_port_assertions
	import eiop_pkg::*;
(
	input wire logic clock, // Clock.
	input wire logic reset_n, // Reset.
	input wire logic hsel, // Bus.
	input wire logic [31:0] haddr, // Bus.
	input wire logic [1:0] htrans, // Bus.
	input wire logic hwrite, // Bus.
	input wire logic hready, // Bus.
	input wire logic [31:0] hrdata, // Bus.
	input wire logic [7:0] pin_in, // Pads.
	input wire logic [7:0] pin_out, // Pads.
	input wire logic [7:0] pin_oe, // Pads.
	input wire logic [7:0] timer_out_en, // Timer.
	input wire logic [7:0] timer_out, // Timer.
	input wire logic [7:0] timer_capture_in, // Timer.
	input wire logic [3:0] ext_timer_clock, // Timer.
	input wire logic interrupt_request_0, // Irq.
	input wire logic interrupt_request_1 // Irq.
);
	default clocking cb @(posedge clock); endclocking
	default disable iff (!reset_n);
	sequence rd_s;
		hsel && hready && htrans == eiop_htrans_nonseq && !hwrite;
	endsequence
	sequence live_s;
		$past(reset_n, 2) && $past(reset_n);
	endsequence
	timer_oe_a: assert property (live_s |->
		(pin_oe & $past(timer_out_en)) == $past(timer_out_en)) else $error("Timer pin not driven.");
	timer_val_a: assert property (live_s |->
		(pin_out & $past(timer_out_en)) == ($past(timer_out) & $past(timer_out_en)))
		else $error("Timer pin value wrong.");
	capture_a: assert property (live_s |-> timer_capture_in == $past(pin_in, 2))
		else $error("Capture input wrong.");
	irq_in_a: assert property (live_s |->
		{interrupt_request_1, interrupt_request_0} == {$past(pin_in[6], 2), $past(pin_in[4], 2)})
		else $error("Interrupt input wrong.");
	clock_in_a: assert property (live_s |-> ext_timer_clock ==
		{$past(pin_in[7], 2), $past(pin_in[5], 2), $past(pin_in[3], 2), $past(pin_in[2], 2)})
		else $error("Timer clock input wrong.");
	dir_read_a: assert property (rd_s ##0 haddr == eiop_off_pin_direction
		|=> hrdata == eiop_undef_read) else $error("Direction read not zero.");
	unmapped_read_a: assert property (rd_s ##0 haddr > eiop_off_pin_level_readback
		|=> hrdata == 32'h0) else $error("Unmapped read not zero.");
	idle_data_a: assert property (!(hsel && hready && htrans == eiop_htrans_nonseq)
		|=> hrdata == 32'h0) else $error("Read data outside a read.");
endmodule
bind eiop_port eiop_port_assertions chk (.*);

// ==== test/tb_top.sv ====
// Self-checking bench for the eight-bit port.
`timescale 1ns/1ns
module tb_top;
	import eiop_pkg::*;
	logic clock = 0, reset_n = 0, hsel = 0, hwrite = 0, hready, hresp, rd_ph = 0;
	logic [1:0] htrans = 0;
	logic [31:0] haddr = 0, hwdata = 0, hrdata, r;
	logic [7:0] pin_in, pin_out, pin_oe, tcap, d, l, oe, out, lvl, np_out, np_oe;
	logic [31:0] np_rdata;
	logic [7:0] ten = 0, tout = 0, pe = 0, po = 0, brd = 0;
	logic [31:0] q[$];
	int seed = 32'h3f2a3fe1, failures = 0, n_compared = 0;
	always #25 clock = ~clock;
	eiop_port dut (.clock(clock), .reset_n(reset_n), .hsel(hsel), .haddr(haddr), .htrans(htrans),
		.hwrite(hwrite), .hsize(eiop_word_index), .hwdata(hwdata), .hready(hready),
		.hrdata(hrdata), .hreadyout(hready), .hresp(hresp), .pin_in(pin_in), .pin_out(pin_out),
		.pin_oe(pin_oe), .timer_out_en(ten), .timer_out(tout), .pattern_enable(pe),
		.pattern_out(po), .timer_capture_in(tcap), .ext_timer_clock(),
		.interrupt_request_0(), .interrupt_request_1());
	eiop_pads pads (.pin_out(pin_out), .pin_oe(pin_oe), .board(brd), .pin_in(pin_in));
	// Second build without the pattern path, fed the same bus and timer inputs.
	eiop_port #(.has_pattern(1'b0)) dut_np (.clock(clock), .reset_n(reset_n), .hsel(hsel),
		.haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(eiop_word_index),
		.hwdata(hwdata), .hready(hready), .hrdata(np_rdata), .hreadyout(), .hresp(),
		.pin_in(pin_in), .pin_out(np_out), .pin_oe(np_oe), .timer_out_en(ten),
		.timer_out(tout), .pattern_enable(pe), .pattern_out(po), .timer_capture_in(),
		.ext_timer_clock(), .interrupt_request_0(), .interrupt_request_1());
	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		n_compared++;
		if (seen !== exp) begin
			failures++;
			$display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask
	task automatic wrap_up;
		$display("compared %0d, failures %0d", n_compared, failures);
		if (failures == 0 && n_compared > 0) $display("== PASSED ==");
		else $display("== FAILED ==");
		$finish;
	endtask
	task automatic wt;
		int n;
		n = 0;
		do begin
			@(posedge clock);
			n++;
		end while (hready !== 1'b1 && n < 9);
		if (hready !== 1'b1) begin
			failures++;
			wrap_up;
		end
	endtask
	task automatic bus(input logic wr, input logic [31:0] a, input logic [31:0] w);
		hsel <= 1'b1;
		htrans <= eiop_htrans_nonseq;
		hwrite <= wr;
		haddr <= a;
		wt;
		htrans <= 2'h0;
		hwdata <= w;
		wt;
	endtask
	task automatic rd(input logic [31:0] a, input logic [31:0] exp);
		q.push_back(exp);
		bus(1'b0, a, 32'h0);
	endtask
	always @(posedge clock) begin
		if (rd_ph) check(hrdata, q.pop_front());
		if (rd_ph) check({31'h0, hresp}, 32'h0);
		rd_ph = hsel && hready && htrans == eiop_htrans_nonseq && !hwrite;
	end
	initial begin
		repeat (2) @(posedge clock);
		reset_n <= 1'b1;
		rd(eiop_off_output_latch, {24'h0, eiop_rst_output_latch});
		rd(32'h0000_000c, 32'h0);
		repeat (12) begin
			r = $random(seed);
			{brd, pe, po, ten} <= r;
			r = $random(seed);
			{d, l} = r[15:0];
			tout <= r[23:16];
			bus(1'b1, eiop_off_pin_direction, {24'h0, d});
			bus(1'b1, eiop_off_output_latch, {24'h0, l});
			bus(1'b1, eiop_off_pin_level_readback, ~r);
			oe = ten | d;
			out = (ten & tout) | (~ten & ((pe & po) | (~pe & l)));
			lvl = (oe & out) | (~oe & brd);
			repeat (3) @(posedge clock);
			@(negedge clock);
			check({24'h0, pin_oe}, {24'h0, oe});
			check({24'h0, pin_out & oe}, {24'h0, out & oe});
			check({24'h0, tcap}, {24'h0, lvl});
			check({24'h0, np_oe}, {24'h0, oe});
			check({24'h0, np_out & oe}, {24'h0, ((ten & tout) | (~ten & l)) & oe});
			@(posedge clock);
			rd(eiop_off_output_latch, {24'h0, l});
			rd(eiop_off_pin_level_readback, {24'h0, (d & l) | (~d & lvl)});
			rd(eiop_off_pin_direction, eiop_undef_read);
			repeat (2) @(posedge clock);
			@(negedge clock);
			check({24'h0, pin_oe}, {24'h0, oe});
			@(posedge clock);
		end
		wrap_up;
	end
endmodule

// ==== verilog/eiop_pin_mux.sv ====
// Per-pin function selection between timer, pattern output and port data.
`timescale 1ns/1ns
module eiop_pin_mux
	import eiop_pkg::*;
#(
	parameter bit has_pattern = 1'b1
) (
	input wire logic timer_out_en, // Timer channel output mode for this pin.
	input wire logic timer_out, // Timer capture/compare output value.
	input wire logic dir, // Direction bit.
	input wire logic latch, // Output data bit.
	input wire logic pat_en, // Pattern enable bit.
	input wire logic pat_out, // Pattern output bit.
	output logic drive_en, // Pin drive enable.
	output logic drive_val // Pin drive value.
);
	always_comb begin
		if (timer_out_en) begin
			drive_en = 1'b1;
			drive_val = timer_out;
		end else if (dir) begin
			drive_en = 1'b1;
			drive_val = (has_pattern && pat_en) ? pat_out : latch; // RL12
		end else begin
			drive_en = 1'b0;
			drive_val = 1'b0;
		end
	end
endmodule

// ==== verilog/eiop_port.sv ====
// Eight-bit I/O port with AHB-Lite registers and pin function multiplexing.
//
// Overview of operation
// RL1 - Direction bit 1 makes pin an output, 0 an input, in port use.
// RL2 - Direction register is write-only; reads give undefined value, no disturbance.
// RL3 - Output data register is readable and writable; it feeds output pins.
// RL4 - Readback of an output pin returns its output data bit.
// RL5 - Readback of an input pin returns the sampled pin level.
// RL6 - Readback register is read-only; writes to it are ignored.
// RL7 - Each pin also serves timer, pattern output and, on some, interrupt input.
// RL8 - Bit 7: timer ch2 B output first, else input/clock D, port or pattern 15.
// RL9 - Bit 6: timer ch2 A output first, else input/irq 1, port or pattern 14.
// RL10 - Bit 5: timer ch1 B output first, else input/clock C, port or pattern 13.
// RL11 - Bit 4: timer ch1 A output first, else input/irq 0, port or pattern 12.
// RL12 - A build option removes the pattern path; direction 1 then drives port data.
// RL13 - Bits 3 to 0 use timer channel 0 and pattern bits 11 to 8 likewise.
//
// Implementation choices: the address map and register access over AHB-Lite.
`timescale 1ns/1ns
module eiop_port
	import eiop_pkg::*;
#(
	parameter bit has_pattern = 1'b1
) (
	input wire logic clock, // System clock, 20 MHz.
	input wire logic reset_n, // Asynchronous reset, active low.
	input wire logic hsel, // Slave select.
	input wire logic [31:0] haddr, // Byte address.
	input wire logic [1:0] htrans, // Transfer type.
	input wire logic hwrite, // Write when high.
	input wire logic [2:0] hsize, // Transfer size.
	input wire logic [31:0] hwdata, // Write data.
	input wire logic hready, // Bus ready in.
	output logic [31:0] hrdata, // Read data.
	output logic hreadyout, // Slave ready.
	output logic hresp, // Response, always OKAY.
	input wire logic [7:0] pin_in, // Pin levels seen at the pads.
	output logic [7:0] pin_out, // Pin drive values.
	output logic [7:0] pin_oe, // Pin output enables, high while driving.
	input wire logic [7:0] timer_out_en, // Per-pin timer output mode.
	input wire logic [7:0] timer_out, // Per-pin timer capture/compare outputs.
	input wire logic [7:0] pattern_enable, // Pattern enables, bits 8 to 15 of the generator.
	input wire logic [7:0] pattern_out, // Pattern outputs, bits 8 to 15 of the generator.
	output logic [7:0] timer_capture_in, // Pin levels to timer capture inputs.
	output logic [3:0] ext_timer_clock, // External clocks A to D.
	output logic interrupt_request_0, // Interrupt input 0 from bit 4.
	output logic interrupt_request_1 // Interrupt input 1 from bit 6.
);
	logic [7:0] pin_direction;
	logic [7:0] next_pin_direction;
	logic [7:0] output_latch;
	logic [7:0] next_output_latch;
	logic [7:0] pin_sample;
	logic [7:0] next_pin_sample;
	logic wr_pending;
	logic next_wr_pending;
	logic [31:0] wr_addr;
	logic [31:0] next_wr_addr;
	logic [31:0] next_hrdata;
	logic [7:0] next_pin_out;
	logic [7:0] next_pin_oe;
	logic [7:0] mux_en;
	logic [7:0] mux_val;
	logic [7:0] next_capture;
	logic [3:0] next_clock;
	logic next_interrupt_request_0;
	logic next_interrupt_request_1;
	logic addr_phase;

	function automatic logic [7:0] readback(input logic [7:0] dir, input logic [7:0] lat,
		input logic [7:0] pins);
		readback = (dir & lat) | (~dir & pins); // RL4 RL5
	endfunction

	// Each pin picks its function; bits 7..0 map to timer ch2, ch1, ch0 pins.
	for (genvar i = 0; i < eiop_width; i++) begin : g_mux
		eiop_pin_mux #(
			.has_pattern(has_pattern)
		) u_mux (
			.timer_out_en(timer_out_en[i]), // RL7 RL8 RL9 RL10 RL11 RL13
			.timer_out(timer_out[i]),
			.dir(pin_direction[i]), // RL1
			.latch(output_latch[i]), // RL3
			.pat_en(pattern_enable[i]),
			.pat_out(pattern_out[i]),
			.drive_en(mux_en[i]),
			.drive_val(mux_val[i])
		);
	end

	assign addr_phase = hsel && hready && (htrans == eiop_htrans_nonseq);

	always_comb begin
		next_pin_direction = pin_direction;
		next_output_latch = output_latch;
		next_wr_pending = addr_phase && hwrite;
		next_wr_addr = addr_phase ? haddr : wr_addr;
		next_hrdata = 32'h0000_0000;
		next_pin_sample = pin_in;
		if (wr_pending) begin
			if (wr_addr == eiop_off_pin_direction) begin
				next_pin_direction = hwdata[7:0]; // RL1
			end else if (wr_addr == eiop_off_output_latch) begin
				next_output_latch = hwdata[7:0]; // RL3
			end
			// Writes to the readback address fall through unused. RL6
		end
		if (addr_phase && !hwrite) begin
			if (haddr == eiop_off_pin_direction) begin
				next_hrdata = eiop_undef_read; // RL2
			end else if (haddr == eiop_off_output_latch) begin
				next_hrdata = {24'h00_0000, output_latch}; // RL3
			end else if (haddr == eiop_off_pin_level_readback) begin
				next_hrdata = {24'h00_0000, readback(pin_direction, output_latch, pin_sample)};
			end
		end
	end

	always_comb begin
		next_pin_out = mux_val;
		next_pin_oe = mux_en;
		// Input side: pin levels feed the timer and interrupt inputs. RL7
		next_capture = pin_sample;
		next_clock = {pin_sample[eiop_clkd_bit], pin_sample[eiop_clkc_bit],
			pin_sample[eiop_clkb_bit], pin_sample[eiop_clka_bit]}; // RL8 RL10 RL13
		next_interrupt_request_0 = pin_sample[eiop_interrupt_request_0_bit]; // RL11
		next_interrupt_request_1 = pin_sample[eiop_interrupt_request_1_bit]; // RL9
	end

	always_ff @(posedge clock or negedge reset_n) begin
		if (!reset_n) begin
			pin_direction <= eiop_rst_pin_direction;
			output_latch <= eiop_rst_output_latch;
			pin_sample <= 8'h00;
			wr_pending <= 1'b0;
			wr_addr <= 32'h0000_0000;
			hrdata <= 32'h0000_0000;
		end else begin
			pin_direction <= next_pin_direction;
			output_latch <= next_output_latch;
			pin_sample <= next_pin_sample;
			wr_pending <= next_wr_pending;
			wr_addr <= next_wr_addr;
			hrdata <= next_hrdata;
		end
	end

	always_ff @(posedge clock or negedge reset_n) begin
		if (!reset_n) begin
			pin_out <= 8'h00;
			pin_oe <= 8'h00;
			timer_capture_in <= 8'h00;
			ext_timer_clock <= 4'h0;
			interrupt_request_0 <= 1'b0;
			interrupt_request_1 <= 1'b0;
			hreadyout <= 1'b1;
			hresp <= 1'b0;
		end else begin
			pin_out <= next_pin_out;
			pin_oe <= next_pin_oe;
			timer_capture_in <= next_capture;
			ext_timer_clock <= next_clock;
			interrupt_request_0 <= next_interrupt_request_0;
			interrupt_request_1 <= next_interrupt_request_1;
			hreadyout <= 1'b1;
			hresp <= 1'b0;
		end
	end
endmodule
